// ===== bench/ppss_host_model.sv
// Purpose: Host side of the parallel port, presents bytes by strobe
// Assumes: Changes pins only just after rising mclk edges
// Notes:   Data is inverted once strobe is high so stale data shows
`timescale 1ns/1ns
module ppss_host_model (
  input wire logic mclk,
  input wire ppss_pkg::ppss_host_out_t hout,
  output logic strobe_n,
  output logic [7:0] data
);
  initial begin
    strobe_n = 1'b1;
    data = 8'h00;
  end

  // ==========================================================
  // Byte transfer
  // rude skips the busy wait so a refusal can be provoked
  task automatic send(input logic [7:0] b, input bit rude,
                      output int w, output logic bmid);
    int n;
    w = 0;
    n = 0;
    while (!rude && hout.busy !== 1'b0 && n < 20000) begin
      @(posedge mclk);
      n++;
    end
    strobe_n <= 1'b0;
    data <= b;
    repeat (70) @(posedge mclk);
    bmid = hout.busy;
    strobe_n <= 1'b1;
    data <= ~b;
    n = 0;
    while (hout.acknowledge_pulse_n !== 1'b0 && n < 20) begin
      @(posedge mclk);
      n++;
    end
    // Next byte only after the acknowledge has ended
    while (hout.acknowledge_pulse_n === 1'b0 && w < 2000) begin
      w++;
      @(posedge mclk);
    end
  endtask
endmodule

// ===== bench/ppss_top_test.sv
// Purpose: Self-checking bench of the parallel port select logic
// Assumes: Host pins change just after rising mclk edges
// Notes:   Queue model predicts which bytes get stored
`timescale 1ns/1ns
module ppss_top_test;
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  ppss_pkg::ppss_wb_req_t req = '0;
  ppss_pkg::ppss_wb_rsp_t rsp;
  ppss_pkg::ppss_host_in_t hin;
  ppss_pkg::ppss_host_out_t hout;
  logic irq, bv, fe, bf, stb_n;
  logic [7:0] bd, hd;
  logic init_n = 1'b1;
  logic alf = 1'b1;
  logic sri = 1'b0;
  logic pend = 1'b0;
  logic flt = 1'b0;
  logic pact = 1'b0;
  logic [31:0] rd;
  logic [2:0] ctrl = 3'h4;
  logic bm;
  logic [7:0] exp_q[$];
  int n_errors = 0;
  int check_count = 0;
  int w;
  bit pup = 1'b1;
  bit desel = 1'b0;

  always #4 mclk = ~mclk;
  assign hin = {stb_n, hd, init_n, alf, sri};

  ppss_top dut_u (.mclk(mclk), .nrst(nrst), .wb_req(req), .wb_rsp(rsp),
    .irq(irq), .host_in(hin), .host_out(hout), .paper_end_in(pend),
    .fault_in(flt), .print_active_in(pact), .byte_valid(bv),
    .byte_data(bd), .feed_enable(fe), .buffer_flush(bf));
  ppss_host_model host_u (.mclk(mclk), .hout(hout), .strobe_n(stb_n),
    .data(hd));

  // ==========================================================
  // Checking and bus tasks
  task automatic results();
    $display("errors %0d checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      n_errors++;
      $display("unexpected at %0t: saw %h want %h", $time, s, e);
    end
  endtask

  task automatic wb(input logic we, input logic [3:0] a,
                    input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: 4'hF, dat: d};
    do begin
      @(posedge mclk);
      n++;
    end while (rsp.ack !== 1'b1 && n < 50);
    rd = rsp.dat;
    if (n >= 50) begin
      n_errors++;
    end
    req <= '0;
  endtask

  task automatic setc(input logic [2:0] c);
    ctrl = c;
    wb(1'b1, ppss_pkg::OFS_CTRL, {29'h0, c});
  endtask

  task automatic st(input logic s, input logic b, input logic e);
    repeat (4) @(posedge mclk);
    chk({hout.selected_status, hout.busy, hout.error_n}, {s, b, e});
  endtask

  function automatic logic [7:0] rb();
    logic [7:0] b;
    b = 8'($urandom);
    if (b == 8'h11 || b == 8'h13) begin
      b = b ^ 8'h40;
    end
    return b;
  endfunction

  // ==========================================================
  // Reference model of storing and selection
  task automatic xmit(input logic [7:0] b);
    bit hon;
    hon = sri && !ctrl[2];
    if (pup) begin
      pup = 1'b0;
    end else if (hon && b == 8'h11) begin
      desel = 1'b0;
    end else if (hon && b == 8'h13) begin
      desel = 1'b1;
    end else if (!(hon && desel)) begin
      exp_q.push_back(b);
    end
    host_u.send(b, 1'b0, w, bm);
    chk(w, 5000 / 8);
    chk(bm, 1'b1);
    chk(hout.busy, 1'b0);
    chk(hout.selected_status, !(hon && desel));
  endtask

  // Each stored byte must be the next one the model predicted
  always @(posedge mclk) begin
    if (nrst && bv === 1'b1) begin
      chk(bd, exp_q.size() ? exp_q.pop_front() : 32'h100);
    end
  end

  // ==========================================================
  // Tests
  initial begin
    void'($urandom(90));
    repeat (20) @(posedge mclk);
    nrst <= 1'b1;
    repeat (4) @(posedge mclk);
    st(1'b0, 1'b1, 1'b0);
    wb(1'b0, ppss_pkg::OFS_CTRL, 0);
    chk(rd, 32'h4);
    wb(1'b0, 4'h6, 0);
    chk(rd, 32'h0);
    host_u.send(rb(), 1'b1, w, bm);
    chk(w, 0);
    setc(3'h5);
    st(1'b0, 1'b0, 1'b1);
    xmit(rb());
    xmit(8'h13);
    xmit(8'h11);
    xmit(rb());
    @(posedge mclk);
    sri <= 1'b1;
    setc(3'h1);
    xmit(8'h13);
    xmit(rb());
    xmit(8'h11);
    xmit(rb());
    xmit(8'h13);
    setc(3'h0);
    st(1'b0, 1'b1, 1'b0);
    host_u.send(rb(), 1'b1, w, bm);
    chk(w, 0);
    setc(3'h1);
    st(1'b0, 1'b0, 1'b1);
    xmit(8'h11);
    for (int i = 0; i < 3; i++) begin
      @(posedge mclk);
      pend <= (i == 0);
      flt <= (i == 1);
      pact <= (i == 2);
      st(i == 2, 1'b1, i == 2);
      chk(hout.paper_out_flag, i == 0);
    end
    @(posedge mclk);
    pact <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      @(posedge mclk);
      alf <= i[0];
      setc({1'b0, i[1], 1'b1});
      repeat (3) @(posedge mclk);
      chk(fe, !i[0] || i[1]);
      wb(1'b0, ppss_pkg::OFS_STATUS, 0);
      chk(rd[5:0], {1'b0, !i[0] || i[1], 1'b0, 3'b101});
    end
    wb(1'b1, ppss_pkg::OFS_IRQ_MASK, 1);
    repeat (3) @(posedge mclk);
    chk(irq, 1'b1);
    wb(1'b1, ppss_pkg::OFS_IRQ_STAT, 1);
    repeat (3) @(posedge mclk);
    chk(irq, 1'b0);
    wb(1'b1, ppss_pkg::OFS_IRQ_MASK, 4);
    xmit(8'h13);
    @(posedge mclk);
    init_n <= 1'b0;
    // Held well past the minimum low time
    repeat (6300) @(posedge mclk);
    chk({bf, hout.busy}, 2'b11);
    init_n <= 1'b1;
    // Init clears the code select state, so codes mode starts deselected
    desel = 1'b1;
    st(1'b0, 1'b0, 1'b1);
    chk(irq, 1'b1);
    wb(1'b0, ppss_pkg::OFS_IRQ_STAT, 0);
    chk(rd[2], 1'b1);
    wb(1'b1, ppss_pkg::OFS_IRQ_STAT, 32'hF);
    repeat (3) @(posedge mclk);
    chk(irq, 1'b0);
    xmit(rb());
    xmit(8'h11);
    xmit(rb());
    repeat (4) @(posedge mclk);
    chk(exp_q.size(), 0);
    results();
  end

  initial begin
    repeat (60000) @(posedge mclk);
    n_errors++;
    results();
  end
endmodule

// ===== logic/ppss_pkg.sv
// Purpose: Shared constants and types of the printer parallel port block
// Assumes: 125 MHz controller clock, classic Wishbone register access
// Notes:   All offsets are byte addresses of aligned 32-bit words
package ppss_pkg;

  // ==========================================================
  // Timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int ACK_PULSE_NS = 5000;
  // Round down so the pulse never runs long
  localparam int ACK_CYCLES = ACK_PULSE_NS / CLK_PERIOD_NS;
  localparam int ACK_CNT_W = 10;

  // ==========================================================
  // In-band select codes
  localparam logic [7:0] CODE_SELECT = 8'h11;
  localparam logic [7:0] CODE_DESELECT = 8'h13;

  // ==========================================================
  // Register map
  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_STATUS = 4'h4;
  localparam logic [3:0] OFS_IRQ_STAT = 4'h8;
  localparam logic [3:0] OFS_IRQ_MASK = 4'hC;

  localparam int CTRL_W = 3;
  localparam int CTRL_ONLINE_BIT = 0;
  localparam int CTRL_FEED_TIE_BIT = 1;
  localparam int CTRL_SELREQ_TIE_BIT = 2;
  // Off-line, feed free, select request tied low as shipped
  localparam logic [2:0] CTRL_RESET = 3'h4;

  localparam int ST_SELECTED_BIT = 0;
  localparam int ST_BUSY_BIT = 1;
  localparam int ST_ERROR_N_BIT = 2;
  localparam int ST_DESEL_BIT = 3;
  localparam int ST_FEED_BIT = 4;
  localparam int ST_PAPER_BIT = 5;
  localparam int ST_LAST_LSB = 8;

  localparam int IRQ_W = 4;
  localparam int IRQ_STORED_BIT = 0;
  localparam int IRQ_DISCARD_BIT = 1;
  localparam int IRQ_INIT_BIT = 2;
  localparam int IRQ_SELCHG_BIT = 3;
  localparam logic [3:0] IRQ_STAT_RESET = 4'h0;
  localparam logic [3:0] IRQ_MASK_RESET = 4'h0;

  // ==========================================================
  // Types
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } ppss_wb_req_t;

  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } ppss_wb_rsp_t;

  typedef struct packed {
    logic strobe_n;
    logic [7:0] data;
    logic init_n;
    logic auto_line_feed_in;
    logic select_request_in;
  } ppss_host_in_t;

  typedef struct packed {
    logic acknowledge_pulse_n;
    logic busy;
    logic paper_out_flag;
    logic error_n;
    logic selected_status;
  } ppss_host_out_t;

  typedef enum logic [2:0] {
    HS_IDLE,
    HS_CAPTURE,
    HS_DECIDE,
    HS_ACK
  } ppss_hs_state_t;

endpackage

// ===== logic/ppss_pulse_timer.sv
// Purpose: One-shot cycle timer for the acknowledge pulse
// Assumes: start and clear are single-cycle or level, clear wins
// Notes:   done is high in the last counted cycle
`timescale 1ns/1ns
module ppss_pulse_timer #(
  parameter int CNT_W = ppss_pkg::ACK_CNT_W,
  parameter logic [CNT_W-1:0] COUNT = CNT_W'(ppss_pkg::ACK_CYCLES)
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic start,
  input wire logic clear,
  output logic running,
  output logic done
);

  // ==========================================================
  // Counter
  logic run_r;
  logic run_nxt;
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;

  assign running = run_r;
  assign done = run_r && (cnt_r == '0);

  always_comb begin
    run_nxt = run_r;
    cnt_nxt = cnt_r;
    if (clear) begin
      run_nxt = 1'b0;
      cnt_nxt = '0;
    end else if (start) begin
      run_nxt = 1'b1;
      cnt_nxt = COUNT - CNT_W'(1);
    end else if (run_r) begin
      if (cnt_r == '0) begin
        run_nxt = 1'b0;
      end else begin
        cnt_nxt = cnt_r - CNT_W'(1);
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      run_r <= 1'b0;
      cnt_r <= '0;
    end else begin
      run_r <= run_nxt;
      cnt_r <= cnt_nxt;
    end
  end

endmodule

// ===== logic/ppss_top.sv
// Purpose: Parallel host port receive side with select and status logic
// Assumes: Host pins are synchronous to mclk; paper and fault come
//          from the print engine; print_active_in high while printing
// Notes:   Registers over classic Wishbone, one ack per access
//
// Notes on behaviour
// - selected_status shows the selected state, high when selected
// - Low auto-feed input, or the tie bit, enables line feed per line
// - Low init resets handshake and select state and flushes buffer
// - error_n low when paper out, off-line or faulted
// - Data entry accepted with select request low; tie bit defaults on
// - Off-line: error low, busy high, selected low, no acknowledge
// - Deselected by DC3: acknowledge bytes but discard them
// - Deselected: DC1 reselects and storing resumes
// - Any error forces selected_status low
// - DC1/DC3 honoured only with select request high
// - Starts deselected after power-up
// - Byte latched while strobe is low, high line is a one
// - Busy high in entry, printing, off-line or error
// - paper_out_flag high while out of paper
//
// The implementer's own choices: the Wishbone slave port and the address map.
`timescale 1ns/1ns
module ppss_top (
  input wire logic mclk,
  input wire logic nrst,
  input wire ppss_pkg::ppss_wb_req_t wb_req,
  output ppss_pkg::ppss_wb_rsp_t wb_rsp,
  output logic irq,
  input wire ppss_pkg::ppss_host_in_t host_in,
  output ppss_pkg::ppss_host_out_t host_out,
  input wire logic paper_end_in,
  input wire logic fault_in,
  input wire logic print_active_in,
  output logic byte_valid,
  output logic [7:0] byte_data,
  output logic feed_enable,
  output logic buffer_flush
);

  // ==========================================================
  // Reset release
  logic rst_meta_r;
  logic rst_n;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rst_meta_r <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n <= rst_meta_r;
    end
  end

  // ==========================================================
  // Declarations
  ppss_pkg::ppss_hs_state_t hs_r;
  ppss_pkg::ppss_hs_state_t hs_nxt;
  logic [ppss_pkg::CTRL_W-1:0] ctrl_r;
  logic [ppss_pkg::CTRL_W-1:0] ctrl_nxt;
  logic [ppss_pkg::IRQ_W-1:0] istat_r;
  logic [ppss_pkg::IRQ_W-1:0] istat_nxt;
  logic [ppss_pkg::IRQ_W-1:0] imask_r;
  logic [ppss_pkg::IRQ_W-1:0] imask_nxt;
  logic [ppss_pkg::IRQ_W-1:0] events;
  ppss_pkg::ppss_wb_rsp_t rsp_r;
  ppss_pkg::ppss_wb_rsp_t rsp_nxt;
  ppss_pkg::ppss_host_out_t hout_r;
  ppss_pkg::ppss_host_out_t hout_nxt;
  logic [7:0] rx_r;
  logic [7:0] rx_nxt;
  logic [7:0] out_byte_r;
  logic [7:0] out_byte_nxt;
  logic out_valid_r;
  logic out_valid_nxt;
  logic dc_sel_r;
  logic dc_sel_nxt;
  logic pwron_r;
  logic pwron_nxt;
  logic init_prev_r;
  logic feed_r;
  logic feed_nxt;
  logic flush_r;
  logic flush_nxt;
  logic irq_r;
  logic online;
  logic err_any;
  logic sel_req_low;
  logic honour_codes;
  logic selected_now;
  logic accept_ok;
  logic code1;
  logic code3;
  logic init_act;
  logic tmr_start;
  logic tmr_done;
  logic wr_acc;
  logic [31:0] status_word;

  // ==========================================================
  // Select and error conditions
  assign online = ctrl_r[ppss_pkg::CTRL_ONLINE_BIT];
  assign err_any = !online || paper_end_in || fault_in;
  assign sel_req_low = ctrl_r[ppss_pkg::CTRL_SELREQ_TIE_BIT] ||
                       !host_in.select_request_in;
  assign honour_codes = !sel_req_low;
  // Power-up flag keeps the port deselected until the first byte
  assign selected_now = !err_any && !pwron_r &&
                        (sel_req_low || dc_sel_r);
  assign accept_ok = !err_any && !print_active_in;
  assign code1 = honour_codes && (rx_r == ppss_pkg::CODE_SELECT);
  assign code3 = honour_codes &&
                 (rx_r == ppss_pkg::CODE_DESELECT);
  assign init_act = !host_in.init_n;

  // ==========================================================
  // Handshake and selection
  always_comb begin
    hs_nxt = hs_r;
    rx_nxt = rx_r;
    dc_sel_nxt = dc_sel_r;
    pwron_nxt = pwron_r;
    out_valid_nxt = 1'b0;
    out_byte_nxt = out_byte_r;
    tmr_start = 1'b0;
    events = '0;
    if (sel_req_low && !pwron_r) begin
      dc_sel_nxt = 1'b1;
    end
    case (hs_r)
      ppss_pkg::HS_IDLE: begin
        if (accept_ok && !host_in.strobe_n) begin
          hs_nxt = ppss_pkg::HS_CAPTURE;
          rx_nxt = host_in.data;
        end
      end
      ppss_pkg::HS_CAPTURE: begin
        if (host_in.strobe_n) begin
          hs_nxt = ppss_pkg::HS_DECIDE;
        end else begin
          rx_nxt = host_in.data;
        end
      end
      ppss_pkg::HS_DECIDE: begin
        hs_nxt = ppss_pkg::HS_ACK;
        tmr_start = 1'b1;
        pwron_nxt = 1'b0;
        if (selected_now) begin
          if (code3) begin
            dc_sel_nxt = 1'b0;
          end else if (!code1) begin
            out_valid_nxt = 1'b1;
            out_byte_nxt = rx_r;
            events[ppss_pkg::IRQ_STORED_BIT] = 1'b1;
          end
        end else begin
          // Acknowledged but dropped while deselected: code select clear (DC3, init or reset), power-up or error
          events[ppss_pkg::IRQ_DISCARD_BIT] = 1'b1;
          if (code1) begin
            dc_sel_nxt = 1'b1;
          end
        end
      end
      ppss_pkg::HS_ACK: begin
        if (tmr_done) begin
          hs_nxt = ppss_pkg::HS_IDLE;
        end
      end
      default: hs_nxt = ppss_pkg::HS_IDLE;
    endcase
    if (!online) begin
      hs_nxt = ppss_pkg::HS_IDLE;
      tmr_start = 1'b0;
    end
    if (init_act) begin
      hs_nxt = ppss_pkg::HS_IDLE;
      dc_sel_nxt = 1'b0;
      out_valid_nxt = 1'b0;
      tmr_start = 1'b0;
    end
    events[ppss_pkg::IRQ_INIT_BIT] = init_act && init_prev_r;
    feed_nxt = !host_in.auto_line_feed_in ||
               ctrl_r[ppss_pkg::CTRL_FEED_TIE_BIT];
    flush_nxt = init_act;
    hout_nxt.selected_status = !err_any && !pwron_nxt &&
                               (sel_req_low || dc_sel_nxt);
    hout_nxt.error_n = !err_any;
    hout_nxt.paper_out_flag = paper_end_in;
    hout_nxt.busy = !accept_ok || init_act ||
                    (hs_nxt != ppss_pkg::HS_IDLE);
    hout_nxt.acknowledge_pulse_n = (hs_nxt != ppss_pkg::HS_ACK);
    events[ppss_pkg::IRQ_SELCHG_BIT] =
      hout_nxt.selected_status != hout_r.selected_status;
  end

  ppss_pulse_timer #(
    .CNT_W(ppss_pkg::ACK_CNT_W),
    .COUNT(ppss_pkg::ACK_CNT_W'(ppss_pkg::ACK_CYCLES))
  ) u_ack_timer (
    .mclk(mclk),
    .rst_n(rst_n),
    .start(tmr_start),
    .clear(init_act || !online),
    .running(),
    .done(tmr_done)
  );

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      hs_r <= ppss_pkg::HS_IDLE;
      rx_r <= 8'h00;
      dc_sel_r <= 1'b0;
      pwron_r <= 1'b1;
      out_valid_r <= 1'b0;
      out_byte_r <= 8'h00;
      init_prev_r <= 1'b1;
      feed_r <= 1'b0;
      flush_r <= 1'b0;
      hout_r <= '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0};
    end else begin
      hs_r <= hs_nxt;
      rx_r <= rx_nxt;
      dc_sel_r <= dc_sel_nxt;
      pwron_r <= pwron_nxt;
      out_valid_r <= out_valid_nxt;
      out_byte_r <= out_byte_nxt;
      init_prev_r <= host_in.init_n;
      feed_r <= feed_nxt;
      flush_r <= flush_nxt;
      hout_r <= hout_nxt;
    end
  end

  // ==========================================================
  // Register slave
  assign wr_acc = wb_req.cyc && wb_req.stb && wb_req.we && !rsp_r.ack;
  assign status_word = {16'h0000, rx_r, 2'b00,
                        hout_r.paper_out_flag, feed_r,
                        !sel_req_low && !dc_sel_r,
                        hout_r.error_n, hout_r.busy,
                        hout_r.selected_status};

  always_comb begin
    ctrl_nxt = ctrl_r;
    imask_nxt = imask_r;
    // New events win over a write-one clear in the same cycle
    istat_nxt = istat_r;
    rsp_nxt.ack = wb_req.cyc && wb_req.stb && !rsp_r.ack;
    rsp_nxt.dat = 32'h0000_0000;
    if (wr_acc && wb_req.sel[0]) begin
      case (wb_req.adr)
        ppss_pkg::OFS_CTRL: ctrl_nxt = wb_req.dat[ppss_pkg::CTRL_W-1:0];
        ppss_pkg::OFS_IRQ_STAT:
          istat_nxt = istat_r & ~wb_req.dat[ppss_pkg::IRQ_W-1:0];
        ppss_pkg::OFS_IRQ_MASK:
          imask_nxt = wb_req.dat[ppss_pkg::IRQ_W-1:0];
        default: ctrl_nxt = ctrl_r;
      endcase
    end
    istat_nxt = istat_nxt | events;
    if (rsp_nxt.ack && !wb_req.we) begin
      case (wb_req.adr)
        ppss_pkg::OFS_CTRL: rsp_nxt.dat = 32'(ctrl_r);
        ppss_pkg::OFS_STATUS: rsp_nxt.dat = status_word;
        ppss_pkg::OFS_IRQ_STAT: rsp_nxt.dat = 32'(istat_r);
        ppss_pkg::OFS_IRQ_MASK: rsp_nxt.dat = 32'(imask_r);
        default: rsp_nxt.dat = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r <= ppss_pkg::CTRL_RESET;
      istat_r <= ppss_pkg::IRQ_STAT_RESET;
      imask_r <= ppss_pkg::IRQ_MASK_RESET;
      rsp_r <= '0;
      irq_r <= 1'b0;
    end else begin
      ctrl_r <= ctrl_nxt;
      istat_r <= istat_nxt;
      imask_r <= imask_nxt;
      rsp_r <= rsp_nxt;
      irq_r <= |(istat_nxt & imask_nxt);
    end
  end

  // ==========================================================
  // Outputs
  assign wb_rsp = rsp_r;
  assign irq = irq_r;
  assign host_out = hout_r;
  assign byte_valid = out_valid_r;
  assign byte_data = out_byte_r;
  assign feed_enable = feed_r;
  assign buffer_flush = flush_r;

  // ==========================================================
  // Checks
  localparam int ACK_LAST = ppss_pkg::ACK_CYCLES - 1;
  logic [ppss_pkg::ACK_CNT_W-1:0] ack_len_r;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ack_len_r <= '0;
    end else if (hout_r.acknowledge_pulse_n) begin
      ack_len_r <= '0;
    end else begin
      ack_len_r <= ack_len_r + ppss_pkg::ACK_CNT_W'(1);
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  AST_OFFLINE_QUIET: assert property (
    !online |=> (!hout_r.selected_status && !hout_r.error_n &&
                 hout_r.busy && hout_r.acknowledge_pulse_n))
    else $error("off-line outputs wrong");
  AST_ERROR_LOW: assert property (
    (paper_end_in || fault_in) |=> !hout_r.error_n)
    else $error("error output not low on fault");
  AST_PAPER_FLAG: assert property (
    paper_end_in |=> hout_r.paper_out_flag)
    else $error("paper out flag missing");
  AST_SEL_ERR: assert property (
    err_any |=> !hout_r.selected_status)
    else $error("selected while in error");
  AST_ACK_WIDTH: assert property (
    (hs_r == ppss_pkg::HS_ACK && tmr_done) |->
      (ack_len_r == ppss_pkg::ACK_CNT_W'(ACK_LAST)))
    else $error("acknowledge pulse width wrong");
  AST_BUSY_ON_STROBE: assert property (
    (hs_r == ppss_pkg::HS_IDLE && accept_ok && !host_in.strobe_n &&
     !init_act) |=> hout_r.busy [*2])
    else $error("busy not raised on strobe");
  AST_BUSY_DURING_ACK: assert property (
    !hout_r.acknowledge_pulse_n |-> hout_r.busy)
    else $error("busy low during acknowledge");
  AST_DC1_RESELECT: assert property (
    (hs_r == ppss_pkg::HS_DECIDE && !selected_now && code1 && online
     && !init_act) |=> dc_sel_r)
    else $error("DC1 did not reselect");
  AST_DESEL_DISCARD: assert property (
    (hs_r == ppss_pkg::HS_DECIDE && !selected_now) |=>
      (!out_valid_r ##1 !out_valid_r))
    else $error("byte stored while deselected");
  AST_STORE_BYTE: assert property (
    (hs_r == ppss_pkg::HS_DECIDE && selected_now && !code1 && !code3
     && online && !init_act) |=>
      (out_valid_r && out_byte_r == $past(rx_r)))
    else $error("stored byte wrong");
  AST_SELREQ_LOW: assert property (
    (sel_req_low && !pwron_r && !err_any) |=> hout_r.selected_status)
    else $error("not selected with request low");
  AST_INIT_RESET: assert property (
    init_act |=> (hs_r == ppss_pkg::HS_IDLE && !dc_sel_r && flush_r))
    else $error("init did not reset");
  AST_FEED: assert property (
    !host_in.auto_line_feed_in |=> feed_r)
    else $error("auto feed not enabled");

endmodule
